/* File: hdl/dmr_device.sv */
// device end: io config and refresh/thermal mode registers, latency selection
//------------------------------------------------------------
// What the document requires
// (RULE1) clock kept within latency frequency limits; not enforced here, nothing checks the clock frequency
// (RULE2) read inversion bit picks read latency column
// (RULE3) latency set bit picks write latency set
// (RULE4) write recovery cycles before auto precharge
// (RULE5) read-to-precharge cycles before auto precharge
// (RULE6) 32-beat reads add eight clocks
// (RULE7) io config register layout at 03H
// (RULE8) two set-point copies, write select access
// (RULE9) device operates from operating set point
// (RULE10) repair protect is sticky until power-on
// (RULE11) protection refuses setting repair entry
// (RULE12) thermal register layout at 04H
// (RULE13) rate codes: 011 is nominal 1x
// (RULE14) rate top bit means above 85 degrees
// (RULE15) code 110 means quarter rate with derating
// (RULE16) controller scales refresh timing by rate
// (RULE17) codes 000 and 111 not assured
// (RULE18) update flag set on change, cleared by read
// (RULE19) update flag zero at power-up
// (RULE20) rate unreliable before initialization completes
// (RULE21) thermal write updates only bits 6:3
// (RULE22) self-refresh abort only on large devices
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dmr_device
  import dmr_pkg::*;
#(
  parameter bit ABORT_SUPPORTED = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // mode command port
  dmr_if.dev mode,
  // registers kept outside this block
  input wire logic [7:0] latencyMode,
  input wire logic [7:0] setPointControl,
  // sensor side
  input wire logic [2:0] sensorRate,
  input wire logic initDone,
  // derived operating values, with the write recovery and burst inputs they use
  output logic [5:0] readLatency,
  output logic [5:0] writeLatency,
  output logic [5:0] readToPrechargeCycles,
  output logic [5:0] writeRecoveryOut,
  input wire logic [5:0] writeRecoveryCycles,
  input wire logic burst32Beats,
  output logic [7:0] ioConfigActive,
  output logic selfRefreshAbort,
  output logic repairEntry,
  output logic [1:0] thermalOffset
);
  //------------------------------------------------------------
  // decode
  //------------------------------------------------------------
  wire logic isWrite = (mode.cmd == DMR_CMD_WRITE);
  wire logic isRead = (mode.cmd == DMR_CMD_READ);
  wire logic hitIo = (mode.addr == ADDR_IO_CONFIG);
  wire logic hitTh = (mode.addr == ADDR_REFRESH_THERMAL);
  wire logic wrSel = setPointControl[SP_WR_BIT];
  wire logic opSel = setPointControl[SP_OP_BIT];

  //------------------------------------------------------------
  // io config copies
  //------------------------------------------------------------
  logic [7:0] ioCopy_reg [2];
  logic [7:0] ioCopy_next [2];
  logic protect_reg;
  logic protect_next;

  // one copy per set point; only the write-selected one is touched [RULE8]
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ioCopy_next[i] = ioCopy_reg[i];
      if (isWrite && hitIo && (wrSel == i[0])) begin
        ioCopy_next[i] = mode.wdata; // [RULE7]
        ioCopy_next[i][IO_PROTECT_BIT] = 1'b0;
      end
    end
  end

  // protection is one sticky flag; writes can only raise it [RULE10]
  assign protect_next = protect_reg | (isWrite & hitIo & mode.wdata[IO_PROTECT_BIT]);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ioCopy_reg[0] <= IO_CONFIG_RESET;
      ioCopy_reg[1] <= IO_CONFIG_RESET;
      protect_reg <= 1'b0;
    end else begin
      ioCopy_reg[0] <= ioCopy_next[0];
      ioCopy_reg[1] <= ioCopy_next[1];
      protect_reg <= protect_next;
    end
  end

  // operating copy drives the device, except the protect bit, which comes from the sticky flag [RULE9]
  always_comb begin
    ioConfigActive = ioCopy_reg[opSel];
    ioConfigActive[IO_PROTECT_BIT] = protect_reg;
  end

  //------------------------------------------------------------
  // sensor inputs: the sensor runs off its own timing
  //------------------------------------------------------------
  logic [2:0] rateMeta_reg;
  logic [2:0] rateSync_reg;
  logic [2:0] rateHold_reg;
  logic initMeta_reg;
  logic initSync_reg;

  // two flops per bit; a code counts only once it held for a cycle,
  // so a word caught mid-change is never reported
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rateMeta_reg <= RATE_1X;
      rateSync_reg <= RATE_1X;
      rateHold_reg <= RATE_1X;
      initMeta_reg <= 1'b0;
      initSync_reg <= 1'b0;
    end else begin
      rateMeta_reg <= sensorRate;
      rateSync_reg <= rateMeta_reg;
      rateHold_reg <= rateSync_reg;
      initMeta_reg <= initDone;
      initSync_reg <= initMeta_reg;
    end
  end

  // costs four cycles of latency, far below any sensible polling rate
  wire logic rateSteady = (rateSync_reg == rateHold_reg);

  //------------------------------------------------------------
  // thermal register
  //------------------------------------------------------------
  logic [3:0] thWrite_reg;
  logic [2:0] rate_reg;
  logic flag_reg;
  logic [3:0] thWriteNext;
  wire logic thWr = isWrite & hitTh;
  wire logic thRd = isRead & hitTh;
  wire logic rateChange = initSync_reg & rateSteady & (rateSync_reg != rate_reg); // [RULE20]

  // only bits 6:3 are writable; entry cannot be raised while protected
  always_comb begin
    thWriteNext = thWrite_reg;
    if (thWr) begin
      thWriteNext = mode.wdata[6:3]; // [RULE21]
      if (protect_reg && mode.wdata[TH_ENTRY_BIT]) begin
        thWriteNext[TH_ENTRY_BIT - 3] = thWrite_reg[TH_ENTRY_BIT - 3]; // [RULE11]
      end
      if (!ABORT_SUPPORTED) begin
        thWriteNext[TH_ABORT_BIT - 3] = 1'b0; // [RULE22]
      end
    end
  end

  // sensor code captured only after init; change wins over read clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      thWrite_reg <= TH_WRITE_RESET;
      rate_reg <= RATE_1X; // [RULE13]
      flag_reg <= 1'b0; // [RULE19]
    end else begin
      thWrite_reg <= thWriteNext;
      if (rateChange) begin
        rate_reg <= rateSync_reg; // [RULE14] [RULE15]
      end
      flag_reg <= rateChange | (flag_reg & ~thRd); // [RULE18]
    end
  end

  assign selfRefreshAbort = thWrite_reg[TH_ABORT_BIT - 3];
  assign repairEntry = thWrite_reg[TH_ENTRY_BIT - 3];
  assign thermalOffset = thWrite_reg[TH_OFFSET_LSB - 3 +: 2];

  //------------------------------------------------------------
  // mode read answer: one cycle after the read
  //------------------------------------------------------------
  wire logic [7:0] thImage = {flag_reg, thWrite_reg, rate_reg}; // [RULE12]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode.rdata <= 8'h00;
      mode.rvalid <= 1'b0;
    end else begin
      mode.rvalid <= isRead;
      // io config is write-only, so it reads back zero
      mode.rdata <= thRd ? thImage : 8'h00;
    end
  end

  //------------------------------------------------------------
  // latency selection
  //------------------------------------------------------------
  wire logic [2:0] rlCode = latencyMode[LAT_RL_LSB +: 3];
  wire logic [2:0] wlCode = latencyMode[LAT_WL_LSB +: 3];
  wire logic invRead = ioConfigActive[IO_RD_INV_BIT];
  wire logic [5:0] rtpBase = RTP_TABLE[rlCode];

  // registered to keep table lookup off the command path
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      readLatency <= 6'h06;
      writeLatency <= 6'h04;
      readToPrechargeCycles <= 6'h08;
      writeRecoveryOut <= 6'h06;
    end else begin
      readLatency <= invRead ? RL_INV[rlCode] : RL_PLAIN[rlCode]; // [RULE2]
      writeLatency <= latencyMode[LAT_WLS_BIT] ? WL_SET_B[wlCode] : WL_SET_A[wlCode]; // [RULE3]
      readToPrechargeCycles <= burst32Beats ? 6'(rtpBase + BURST32_RTP_EXTRA) : rtpBase; // [RULE5] [RULE6]
      writeRecoveryOut <= writeRecoveryCycles; // [RULE4]
    end
  end
endmodule
`default_nettype wire

/* File: pkg/dmr_pkg.sv */
// package: mode register addresses, fields, codes and latency tables
package dmr_pkg;
  // mode addresses
  localparam logic [5:0] ADDR_IO_CONFIG = 6'h03;
  localparam logic [5:0] ADDR_REFRESH_THERMAL = 6'h04;
  // io config fields
  localparam int IO_PULLUP_BIT = 0;
  localparam int IO_POSTAMBLE_BIT = 1;
  localparam int IO_PROTECT_BIT = 2;
  localparam int IO_PULLDOWN_LSB = 3;
  localparam int IO_RD_INV_BIT = 6;
  localparam int IO_WR_INV_BIT = 7;
  localparam logic [7:0] IO_CONFIG_RESET = 8'h30;
  // thermal fields
  localparam int TH_ABORT_BIT = 3;
  localparam int TH_ENTRY_BIT = 4;
  localparam int TH_OFFSET_LSB = 5;
  localparam int TH_FLAG_BIT = 7;
  localparam logic [7:0] TH_WRITE_MASK = 8'h78;
  localparam logic [3:0] TH_WRITE_RESET = 4'h0;
  // refresh rate codes
  localparam logic [2:0] RATE_4X = 3'h1;
  localparam logic [2:0] RATE_2X = 3'h2;
  localparam logic [2:0] RATE_1X = 3'h3;
  localparam logic [2:0] RATE_HALF = 3'h4;
  localparam logic [2:0] RATE_QUARTER = 3'h5;
  localparam logic [2:0] RATE_QUARTER_DERATE = 3'h6;
  // latency mode fields
  localparam int LAT_RL_LSB = 0;
  localparam int LAT_WL_LSB = 3;
  localparam int LAT_WLS_BIT = 6;
  localparam logic [7:0] LAT_RESET = 8'h00;
  // set point control fields
  localparam int SP_WR_BIT = 6;
  localparam int SP_OP_BIT = 7;
  // extra clocks for 32-beat reads
  localparam logic [5:0] BURST32_RTP_EXTRA = 6'h08;
  // latency tables, indexed by the 3-bit code
  typedef logic [5:0] dmr_lat_t [8];
  localparam dmr_lat_t RL_PLAIN = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
  localparam dmr_lat_t RL_INV = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
  localparam dmr_lat_t WL_SET_A = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
  localparam dmr_lat_t WL_SET_B = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};
  localparam dmr_lat_t RTP_TABLE = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10};
  // command codes on the mode port
  typedef enum logic [1:0] {
    DMR_CMD_IDLE = 2'h0,
    DMR_CMD_WRITE = 2'h1,
    DMR_CMD_READ = 2'h2
  } dmr_cmd_t;
  // controller register map (AXI4-Lite byte offsets)
  localparam logic [4:0] CTL_CMD = 5'h00;
  localparam logic [4:0] CTL_WDATA = 5'h04;
  localparam logic [4:0] CTL_STATUS = 5'h08;
  localparam logic [4:0] CTL_RDATA = 5'h0C;
  localparam logic [4:0] CTL_CONFIG = 5'h10;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

/* File: pkg/dmr_if.sv */
// interface: mode register command port between controller and device
`timescale 1ns/1ps
`default_nettype none
interface dmr_if;
  import dmr_pkg::*;
  dmr_cmd_t cmd;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  modport ctrl (output cmd, output addr, output wdata, input rdata, input rvalid);
  modport dev (input cmd, input addr, input wdata, output rdata, output rvalid);
endinterface
`default_nettype wire

/* File: hdl/dmr_controller.sv */
// controller end: AXI4-Lite registers issuing mode write/read commands
`timescale 1ns/1ps
`default_nettype none
module dmr_controller
  import dmr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // mode port
  dmr_if.ctrl mode,
  // refresh scaling to scheduler
  output logic [2:0] refreshRate,
  output logic rateUnsafe
);
  //------------------------------------------------------------
  // write channel: take address and data in any order
  //------------------------------------------------------------
  logic [4:0] awAddr_reg;
  logic awHave_reg;
  logic [31:0] wData_reg;
  logic wHave_reg;
  logic wStrb0_reg;
  logic [7:0] cmdData_reg;
  logic [5:0] cmdAddr_reg;
  logic [1:0] cmdKind_reg;
  logic busy_reg;
  logic [7:0] rdBack_reg;
  logic initDone_reg;
  assign awready = ~awHave_reg & ~bvalid;
  assign wready = ~wHave_reg & ~bvalid;
  wire logic doWrite = awHave_reg & wHave_reg & ~bvalid;
  wire logic wOk = (awAddr_reg == CTL_CMD) | (awAddr_reg == CTL_WDATA) | (awAddr_reg == CTL_CONFIG);
  wire logic issue = doWrite & (awAddr_reg == CTL_CMD) & wData_reg[0] & ~busy_reg;

  // latch channels, then perform the write once both are held
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= 5'h00;
      wData_reg <= 32'h00000000;
      wStrb0_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddr_reg <= awaddr;
        awHave_reg <= 1'b1;
      end
      if (wvalid && wready) begin
        wData_reg <= wdata;
        wStrb0_reg <= wstrb[0]; // strobe travels with its data beat
        wHave_reg <= 1'b1;
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wOk ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------
  // command registers and mode port drive
  //------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmdData_reg <= 8'h00;
      cmdAddr_reg <= 6'h00;
      cmdKind_reg <= 2'h0;
      initDone_reg <= 1'b0;
      busy_reg <= 1'b0;
      rdBack_reg <= 8'h00;
      mode.cmd <= DMR_CMD_IDLE;
      mode.addr <= 6'h00;
      mode.wdata <= 8'h00;
    end else begin
      mode.cmd <= DMR_CMD_IDLE;
      if (doWrite && awAddr_reg == CTL_WDATA && wStrb0_reg) begin
        cmdData_reg <= wData_reg[7:0];
        cmdAddr_reg <= wData_reg[13:8];
      end
      if (doWrite && awAddr_reg == CTL_CONFIG) begin
        initDone_reg <= wData_reg[0];
      end
      // one-cycle command pulse; a read holds busy until answered
      if (issue) begin
        mode.cmd <= wData_reg[1] ? DMR_CMD_READ : DMR_CMD_WRITE;
        mode.addr <= cmdAddr_reg;
        mode.wdata <= cmdData_reg;
        busy_reg <= wData_reg[1];
        cmdKind_reg <= wData_reg[2:1];
      end else if (mode.rvalid) begin
        busy_reg <= 1'b0;
        rdBack_reg <= mode.rdata;
      end
    end
  end

  // scheduler sees the rate only after init; bad codes flagged [RULE16] [RULE17] [RULE20]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refreshRate <= RATE_1X;
      rateUnsafe <= 1'b0;
    end else if (mode.rvalid && initDone_reg && cmdAddr_reg == ADDR_REFRESH_THERMAL) begin
      refreshRate <= mode.rdata[2:0];
      rateUnsafe <= (mode.rdata[2:0] == 3'h0) | (mode.rdata[2:0] == 3'h7);
    end
  end

  //------------------------------------------------------------
  // read channel
  //------------------------------------------------------------
  assign arready = ~rvalid;
  wire logic [31:0] statusWord = {27'h0000000, cmdKind_reg, rateUnsafe, initDone_reg, busy_reg};
  logic [31:0] readMux;
  always_comb begin
    case (araddr)
      CTL_WDATA: readMux = {18'h00000, cmdAddr_reg, cmdData_reg};
      CTL_STATUS: readMux = statusWord;
      CTL_RDATA: readMux = {24'h000000, rdBack_reg};
      CTL_CONFIG: readMux = {31'h00000000, initDone_reg};
      default: readMux = 32'h00000000;
    endcase
  end
  wire logic rOk = (araddr == CTL_CMD) | (araddr == CTL_WDATA) | (araddr == CTL_STATUS) |
                   (araddr == CTL_RDATA) | (araddr == CTL_CONFIG);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= AXI_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= readMux;
      rresp <= rOk ? AXI_OKAY : AXI_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/dmr_checker.sv */
// checker: mode port answers and thermal register readback
`timescale 1ns/1ps
`default_nettype none
module dmr_checker
  import dmr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // mode port
  input wire dmr_cmd_t cmd,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // decoded mode commands
  wire logic wrIo = cmd == DMR_CMD_WRITE && addr == ADDR_IO_CONFIG;
  wire logic wrTh = cmd == DMR_CMD_WRITE && addr == ADDR_REFRESH_THERMAL;
  wire logic rdIo = cmd == DMR_CMD_READ && addr == ADDR_IO_CONFIG;
  wire logic rdTh = cmd == DMR_CMD_READ && addr == ADDR_REFRESH_THERMAL;
  // shadow of writable thermal bits; protect never clears, so entry stays locked
  logic prot_reg;
  logic [3:0] therm_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prot_reg <= 1'b0;
      therm_reg <= TH_WRITE_RESET;
    end else begin
      if (wrIo) prot_reg <= prot_reg | wdata[IO_PROTECT_BIT];
      if (wrTh) therm_reg <= {wdata[6:5], wdata[4] & (~prot_reg | therm_reg[1]), wdata[3]};
    end
  end
  // answers on the mode port
  a_read_answer: assert property (cmd == DMR_CMD_READ |=> rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (rvalid |-> $past(cmd) == DMR_CMD_READ)
    else $error("answer without read");
  a_answer_single: assert property (rvalid && cmd != DMR_CMD_READ |=> !rvalid)
    else $error("answer held too long");
  a_write_silent: assert property (cmd == DMR_CMD_WRITE |=> !rvalid)
    else $error("write produced an answer");
  a_io_reads_zero: assert property (rdIo |=> rdata == 8'h00)
    else $error("io config read not zero");
  // thermal readback against the shadow
  a_offset_field: assert property (rdTh |=> rdata[6:5] == therm_reg[3:2])
    else $error("thermal offset mismatch");
  a_abort_field: assert property (rdTh |=> rdata[TH_ABORT_BIT] == therm_reg[0])
    else $error("abort bit mismatch");
  a_entry_blocked: assert property (rdTh && prot_reg |=> rdata[TH_ENTRY_BIT] == therm_reg[1])
    else $error("entry bit set while protected");
endmodule
`default_nettype wire

/* File: sim/tb_dram_io_thermal_mode_regs.sv */
// testbench: controller and device joined over the mode port
`timescale 1ns/1ps
`default_nettype none
module tb_dram_io_thermal_mode_regs
  import dmr_pkg::*;
;
  //------------------------------
  // signals and instances
  //------------------------------
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, rateUnsafe, selfRefreshAbort, repairEntry;
  logic burst32Beats = 1'b0, initDone = 1'b0;
  logic [1:0] bresp, rresp, thermalOffset, lastBresp;
  logic [7:0] latencyMode = 8'h00, setPointControl = 8'h00, ioConfigActive;
  logic [2:0] sensorRate = 3'h2, refreshRate;
  logic [5:0] writeRecoveryCycles = 6'h06, readLatency, writeLatency, readToPrechargeCycles, writeRecoveryOut;
  int n_errors = 0, n_tests = 0;
  dmr_if mode_if ();
  dmr_device dmr_device_inst (.clock, .reset_n, .mode(mode_if), .latencyMode, .setPointControl, .sensorRate,
    .initDone, .readLatency, .writeLatency, .readToPrechargeCycles, .writeRecoveryOut, .writeRecoveryCycles,
    .burst32Beats, .ioConfigActive, .selfRefreshAbort, .repairEntry, .thermalOffset);
  dmr_controller dmr_controller_inst (.clock, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .mode(mode_if), .refreshRate, .rateUnsafe);
  dmr_checker dmr_checker_inst (.clock(clock), .reset_n(reset_n), .cmd(mode_if.cmd), .addr(mode_if.addr),
    .wdata(mode_if.wdata), .rdata(mode_if.rdata), .rvalid(mode_if.rvalid));
  // 200 MHz clock; the latency sweep ignores per-code frequency bands, not checked here
  always #2.5 clock = ~clock;
  //------------------------------
  // bus tasks
  //------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_w(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    lastBresp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_r(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // poll busy; the watchdog bounds a hang
  task automatic wait_idle();
    logic [31:0] v;
    logic [1:0] r;
    do axi_r(CTL_STATUS, v, r); while (v[0] !== 1'b0);
  endtask
  task automatic mode_w(input logic [5:0] ma, input logic [7:0] d);
    axi_w(CTL_WDATA, {18'h0, ma, d});
    axi_w(CTL_CMD, 32'h1);
    wait_idle();
  endtask
  task automatic mode_r(input logic [5:0] ma, output logic [7:0] d);
    logic [31:0] v;
    logic [1:0] r;
    axi_w(CTL_WDATA, {18'h0, ma, 8'h00});
    axi_w(CTL_CMD, 32'h3);
    wait_idle();
    axi_r(CTL_RDATA, v, r);
    d = v[7:0];
  endtask
  task automatic final_report();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //------------------------------
  // tests
  //------------------------------
  initial begin
    logic [7:0] v;
    logic [31:0] w;
    logic [1:0] r;
    logic [2:0] codes [7] = '{3'h2, 3'h1, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7};
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    // rate held at nominal until init completes
    mode_r(ADDR_REFRESH_THERMAL, v);
    check(32'(v), 32'h03);
    initDone <= 1'b1;
    axi_w(CTL_CONFIG, 32'h1);
    check(32'(lastBresp), 32'(AXI_OKAY));
    // each new rate raises the flag once; 0 and 7 flagged unsafe
    foreach (codes[i]) begin
      sensorRate <= codes[i];
      repeat (3) @(posedge clock);
      mode_r(ADDR_REFRESH_THERMAL, v);
      check(32'(v), 32'({1'b1, 4'h0, codes[i]}));
      check(32'({rateUnsafe, refreshRate}), 32'({codes[i] == 3'h0 || codes[i] == 3'h7, codes[i]}));
      mode_r(ADDR_REFRESH_THERMAL, v);
      check(32'(v[7]), 32'h0);
    end
    // latency columns, sets and 32-beat extra
    for (int p = 0; p < 2; p++) begin
      mode_w(ADDR_IO_CONFIG, p ? 8'h70 : 8'h30);
      burst32Beats <= p[0];
      check(32'(ioConfigActive), p ? 32'h70 : 32'h30);
      for (int k = 0; k < 8; k++) begin
        latencyMode <= {1'b0, p[0], k[2:0], k[2:0]};
        writeRecoveryCycles <= 6'(k + 6);
        repeat (3) @(posedge clock);
        check(32'(readLatency), 32'(p ? RL_INV[k] : RL_PLAIN[k]));
        check(32'(writeLatency), 32'(p ? WL_SET_B[k] : WL_SET_A[k]));
        check(32'(readToPrechargeCycles), 32'(RTP_TABLE[k] + (p ? 6'h08 : 6'h00)));
        check(32'(writeRecoveryOut), 32'(k + 6));
      end
    end
    // inactive copy written, then made active
    setPointControl <= 8'h40;
    mode_w(ADDR_IO_CONFIG, 8'h81);
    check(32'(ioConfigActive), 32'h70);
    mode_r(ADDR_IO_CONFIG, v);
    check(32'(v), 32'h00);
    setPointControl <= 8'hC0;
    repeat (3) @(posedge clock);
    check(32'(ioConfigActive), 32'h81);
    check(32'(readLatency), 32'(RL_PLAIN[7]));
    // only bits 6:3 of a thermal write land
    mode_w(ADDR_REFRESH_THERMAL, 8'hFF);
    mode_r(ADDR_REFRESH_THERMAL, v);
    check(32'(v), 32'h7F);
    check(32'({selfRefreshAbort, repairEntry, thermalOffset}), 32'hF);
    // protect survives a clearing write and blocks entry
    mode_w(ADDR_REFRESH_THERMAL, 8'h00);
    mode_w(ADDR_IO_CONFIG, 8'h04);
    mode_w(ADDR_IO_CONFIG, 8'h00);
    check(32'(ioConfigActive), 32'h04);
    mode_w(ADDR_REFRESH_THERMAL, 8'h18);
    check(32'({selfRefreshAbort, repairEntry}), 32'h2);
    mode_r(ADDR_REFRESH_THERMAL, v);
    check(32'(v), 32'h0F);
    // unmapped register
    axi_r(5'h14, w, r);
    check(32'(r), 32'(AXI_SLVERR));
    axi_w(5'h14, 32'h0);
    check(32'(lastBresp), 32'(AXI_SLVERR));
    axi_r(CTL_CONFIG, w, r);
    check(32'(r), 32'(AXI_OKAY));
    check(w, 32'h1);
    final_report();
  end
  // watchdog: the run needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule
`default_nettype wire
